// ==== pkg/orret_defs.vh ====
// constants for the or and return execution slice
`ifndef ORRET_DEFS_VH
`define ORRET_DEFS_VH
`define ORRET_OP_NONE   3'h0
`define ORRET_OP_OR_M   3'h1
`define ORRET_OP_OR_X   3'h2
`define ORRET_OP_TO_MEM 3'h3
`define ORRET_OP_SUBR   3'h4
`define ORRET_OP_RETX   3'h5
`define ORRET_OP_INTR   3'h6
`define ORRET_ZERO8     8'h00
`define ORRET_PC_RST    13'h0000
`endif

// ==== rtl/orret_alu.v ====
// bitwise or unit with zero detect
`include "orret_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module orret_alu (
   input  wire [7:0] a,
   input  wire [7:0] b,
   output wire [7:0] y,
   output wire       zero
);
   // or and zero detect
   assign y    = a | b;
   assign zero = (y == `ORRET_ZERO8);
endmodule // orret_alu
`default_nettype wire

// ==== rtl/orret_exec.v ====
// execution of or and return instructions
`include "orret_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - or working register with memory byte, result to working register
// - or working register with immediate, result to working register
// - or memory byte with working register, result back to memory
// - plain return pops program counter, flags untouched
// - return with immediate pops pc and loads working register
// - interrupt return pops pc and sets master interrupt enable
// - pending interrupt is taken before resuming main program
module orret_exec (
   input  wire        CLK,
   input  wire        RESET,
   input  wire        CE,
   input  wire        OP_VALID,
   input  wire [2:0]  OP_CODE,
   input  wire [7:0]  IMM_DATA,
   input  wire [7:0]  MEM_RDATA,
   input  wire [12:0] STACK_TOP,
   input  wire        IRQ_PENDING,
   input  wire        INT_ENABLE_CLEAR,
   output wire [7:0]  WORKING_REG,
   output wire        ZERO_FLAG,
   output wire        MASTER_INT_ENABLE,
   output wire [12:0] PC,
   output wire [7:0]  MEM_WDATA,
   output wire        MEM_WE,
   output wire        STACK_POP,
   output wire        IRQ_TAKE
);

   // -------- or datapath nets --------
   wire [7:0]  or_b;        // second or operand
   wire [7:0]  or_y;        // or result
   wire        or_z;        // or result is zero

   // -------- decoded instruction strobes --------
   wire        dec_or_mem;  // or memory byte into working register
   wire        dec_or_imm;  // or immediate into working register
   wire        dec_or_dst;  // or result back to memory
   wire        dec_subr;    // plain subroutine return
   wire        dec_retx;    // return loading immediate
   wire        dec_intr;    // interrupt return
   wire        dec_any_or;  // any of the three or forms
   wire        dec_any_ret; // any of the three returns

   // -------- architectural state --------
   reg  [7:0]  working_reg_r;
   reg  [7:0]  working_reg_nxt;
   reg         zero_flag_r;
   reg         zero_flag_nxt;
   reg         int_enable_r;
   reg         int_enable_nxt;
   reg  [12:0] pc_r;
   reg  [12:0] pc_nxt;

   // -------- memory write port --------
   reg  [7:0]  mem_wdata_r;
   reg  [7:0]  mem_wdata_nxt;
   reg         mem_we_r;
   reg         mem_we_nxt;

   // -------- stack and interrupt pulses --------
   reg         stack_pop_r;
   reg         stack_pop_nxt;
   reg         irq_take_r;
   reg         irq_take_nxt;

   // opcode decode, qualified by valid
   assign dec_or_mem  = OP_VALID && (OP_CODE == `ORRET_OP_OR_M);
   assign dec_or_imm  = OP_VALID && (OP_CODE == `ORRET_OP_OR_X);
   assign dec_or_dst  = OP_VALID && (OP_CODE == `ORRET_OP_TO_MEM);
   assign dec_subr    = OP_VALID && (OP_CODE == `ORRET_OP_SUBR);
   assign dec_retx    = OP_VALID && (OP_CODE == `ORRET_OP_RETX);
   assign dec_intr    = OP_VALID && (OP_CODE == `ORRET_OP_INTR);

   // grouped strobes for the shared parts
   assign dec_any_or  = dec_or_mem | dec_or_imm | dec_or_dst;
   assign dec_any_ret = dec_subr | dec_retx | dec_intr;

   // second or operand: immediate or memory byte
   assign or_b = dec_or_imm ? IMM_DATA : MEM_RDATA;

   // shared or unit, first operand always the working register
   orret_alu u_alu (
      .a    (working_reg_r),
      .b    (or_b),
      .y    (or_y),
      .zero (or_z)
   );

   // working register next value
   always @* begin
      working_reg_nxt = working_reg_r;
      if (dec_or_mem) begin
         working_reg_nxt = or_y;
      end
      if (dec_or_imm) begin
         working_reg_nxt = or_y;
      end
      if (dec_retx) begin
         working_reg_nxt = IMM_DATA;
      end
   end

   // zero flag next value, returns leave it alone
   always @* begin
      zero_flag_nxt = zero_flag_r;
      if (dec_any_or) begin
         zero_flag_nxt = or_z;
      end
   end

   // master interrupt enable next value
   always @* begin
      int_enable_nxt = int_enable_r;
      // clear request from elsewhere in the core
      if (INT_ENABLE_CLEAR) begin
         int_enable_nxt = 1'b0;
      end
      // interrupt return sets enable, wins over clear
      if (dec_intr) begin
         int_enable_nxt = 1'b1;
      end
   end

   // program counter and stack pop
   always @* begin
      pc_nxt        = pc_r;
      stack_pop_nxt = 1'b0;
      // any return restores pc from stack
      if (dec_any_ret) begin
         pc_nxt        = STACK_TOP;
         stack_pop_nxt = 1'b1;
      end
   end

   // memory write port
   always @* begin
      mem_wdata_nxt = mem_wdata_r;
      mem_we_nxt    = 1'b0;
      if (dec_or_dst) begin
         mem_wdata_nxt = or_y;
         mem_we_nxt    = 1'b1;
      end
   end

   // interrupt service request
   always @* begin
      irq_take_nxt = 1'b0;
      // pending interrupt served before main program
      if (dec_intr) begin
         irq_take_nxt = IRQ_PENDING;
      end
   end

   // architectural state registers, frozen while ce low
   always @(posedge CLK) begin
      if (RESET) begin
         working_reg_r <= `ORRET_ZERO8;
         zero_flag_r   <= 1'b0;
         int_enable_r  <= 1'b0;
         pc_r          <= `ORRET_PC_RST;
      end else if (CE) begin
         working_reg_r <= working_reg_nxt;
         zero_flag_r   <= zero_flag_nxt;
         int_enable_r  <= int_enable_nxt;
         pc_r          <= pc_nxt;
      end
   end

   // memory write registers, pulse held while ce low
   always @(posedge CLK) begin
      if (RESET) begin
         mem_wdata_r <= `ORRET_ZERO8;
         mem_we_r    <= 1'b0;
      end else if (CE) begin
         mem_wdata_r <= mem_wdata_nxt;
         mem_we_r    <= mem_we_nxt;
      end
   end

   // stack and interrupt pulse registers
   always @(posedge CLK) begin
      if (RESET) begin
         stack_pop_r <= 1'b0;
         irq_take_r  <= 1'b0;
      end else if (CE) begin
         stack_pop_r <= stack_pop_nxt;
         irq_take_r  <= irq_take_nxt;
      end
   end

   // outputs straight from the flip-flops
   assign WORKING_REG       = working_reg_r;
   assign ZERO_FLAG         = zero_flag_r;
   assign MASTER_INT_ENABLE = int_enable_r;
   assign PC                = pc_r;
   assign MEM_WDATA         = mem_wdata_r;
   assign MEM_WE            = mem_we_r;
   assign STACK_POP         = stack_pop_r;
   assign IRQ_TAKE          = irq_take_r;

endmodule // orret_exec
`default_nettype wire

// ==== sim/orret_exec_assertions.sv ====
// checker for the or and return slice
`timescale 1ns/100ps
`default_nettype none
module orret_chk (input wire CLK, RESET, CE, OP_VALID, IRQ_PENDING,
   ZERO_FLAG, MASTER_INT_ENABLE, MEM_WE, STACK_POP, IRQ_TAKE,
   input wire [2:0] OP_CODE, input wire [12:0] STACK_TOP, PC,
   input wire [7:0] IMM_DATA, MEM_RDATA, WORKING_REG, MEM_WDATA);
   // accepted op and its or result
   wire g = CE & OP_VALID & ~RESET;
   wire [7:0] r = WORKING_REG | (OP_CODE == 3'h2 ? IMM_DATA : MEM_RDATA);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   a_or_mem: assert property (g && OP_CODE == 3'h1 |=>
      WORKING_REG == $past(r)) else $error("or mem");
   a_or_imm: assert property (g && OP_CODE == 3'h2 |=>
      WORKING_REG == $past(r)) else $error("or imm");
   a_or_store: assert property (g && OP_CODE == 3'h3 |=>
      MEM_WE && MEM_WDATA == $past(r)) else $error("or store");
   a_ret_pop: assert property (g && OP_CODE == 3'h4 |=>
      PC == $past(STACK_TOP) && $stable(ZERO_FLAG)) else $error("ret");
   a_retx_load: assert property (g && OP_CODE == 3'h5 |=>
      WORKING_REG == $past(IMM_DATA)) else $error("retx");
   a_interrupt_return_instr_emi: assert property (g && OP_CODE == 3'h6 |=>
      MASTER_INT_ENABLE && STACK_POP) else $error("interrupt_return_instr");
   a_interrupt_return_instr_irq: assert property (g && OP_CODE == 3'h6 |=>
      IRQ_TAKE == $past(IRQ_PENDING)) else $error("irq");
   a_zero_flag: assert property (g && OP_CODE inside {1, 2, 3} |=>
      ZERO_FLAG == ($past(r) == 8'h00)) else $error("zero");
endmodule // orret_chk
`default_nettype wire
bind orret_exec orret_chk orret_chk_i (.CLK(CLK), .RESET(RESET), .CE(CE),
   .OP_VALID(OP_VALID), .IRQ_PENDING(IRQ_PENDING), .ZERO_FLAG(ZERO_FLAG),
   .MASTER_INT_ENABLE(MASTER_INT_ENABLE), .MEM_WE(MEM_WE),
   .STACK_POP(STACK_POP), .IRQ_TAKE(IRQ_TAKE), .OP_CODE(OP_CODE),
   .STACK_TOP(STACK_TOP), .PC(PC), .IMM_DATA(IMM_DATA),
   .MEM_RDATA(MEM_RDATA), .WORKING_REG(WORKING_REG),
   .MEM_WDATA(MEM_WDATA));

// ==== sim/tb_top.sv ====
// bench for the or and return slice
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic CLK=0, RESET=1, CE=1, OP_VALID=0, IRQ_PENDING=1;
   logic INT_ENABLE_CLEAR=0;
   logic [2:0] OP_CODE=0;
   logic [7:0] IMM_DATA=0, MEM_RDATA=0;
   logic [12:0] STACK_TOP=0;
   wire [7:0] WORKING_REG, MEM_WDATA;
   wire [12:0] PC;
   wire ZERO_FLAG, MASTER_INT_ENABLE, MEM_WE, STACK_POP, IRQ_TAKE;
   int fail_count=0, comparisons=0;
   orret_exec orret_exec_i (.CLK(CLK), .RESET(RESET), .CE(CE),
      .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .IMM_DATA(IMM_DATA),
      .MEM_RDATA(MEM_RDATA), .STACK_TOP(STACK_TOP),
      .IRQ_PENDING(IRQ_PENDING), .INT_ENABLE_CLEAR(INT_ENABLE_CLEAR),
      .WORKING_REG(WORKING_REG), .ZERO_FLAG(ZERO_FLAG),
      .MASTER_INT_ENABLE(MASTER_INT_ENABLE), .PC(PC),
      .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .STACK_POP(STACK_POP),
      .IRQ_TAKE(IRQ_TAKE));
   always #5 CLK = ~CLK;
   // one op held over one edge
   task op(input [2:0] c, input [7:0] i, m, input [12:0] s);
      @(posedge CLK); #1 {OP_CODE,IMM_DATA,MEM_RDATA,STACK_TOP} = {c,i,m,s};
      OP_VALID = 1; @(posedge CLK); #1 OP_VALID = 0;
   endtask
   task ck(input string n, input [12:0] e, g);
      comparisons++;
      if (g !== e) begin fail_count++; $display("FAIL %s %h %h", n, e, g); end
   endtask
   task t_or;
      op(1, 0, 0, 0); ck("zero", 1, ZERO_FLAG);
      op(2, 8'h5A, 8'hFF, 0); ck("wreg", 8'h5A, WORKING_REG);
      op(1, 0, 8'hA0, 0); ck("wreg", 8'hFA, WORKING_REG);
      op(3, 0, 8'h05, 0); ck("wdata", 8'hFF, MEM_WDATA);
      ck("we", 1, MEM_WE);
      ck("wreg", 8'hFA, WORKING_REG);
      ck("zero", 0, ZERO_FLAG);
   endtask
   task t_ret;
      op(4, 0, 0, 13'h1ABC); ck("pc", 13'h1ABC, PC);
      ck("pop", 1, STACK_POP);
      ck("zero", 0, ZERO_FLAG);
      op(5, 8'h3C, 0, 13'h0123); ck("wreg", 8'h3C, WORKING_REG);
      ck("pc", 13'h0123, PC);
      op(6, 0, 0, 13'h0F0F); ck("emi", 1, MASTER_INT_ENABLE);
      ck("take", 1, IRQ_TAKE);
      ck("pc", 13'h0F0F, PC);
   endtask
   // enable clear, no pending irq, ce freeze, mid-run reset
   task t_ctl;
      @(posedge CLK); #1 INT_ENABLE_CLEAR = 1;
      @(posedge CLK); #1 ck("emi", 0, MASTER_INT_ENABLE);
      IRQ_PENDING = 0;
      op(6, 0, 0, 13'h0AAA); ck("emi", 1, MASTER_INT_ENABLE);
      ck("take", 0, IRQ_TAKE);
      INT_ENABLE_CLEAR = 0;
      CE = 0;
      op(2, 8'h01, 0, 0); ck("wreg", 8'h3C, WORKING_REG);
      ck("pop", 1, STACK_POP);
      CE = 1;
      @(posedge CLK); #1 RESET = 1;
      @(posedge CLK); #1 RESET = 0;
      ck("pc", 0, PC);
      ck("wreg", 0, WORKING_REG);
      op(2, 8'h80, 0, 0); ck("wreg", 8'h80, WORKING_REG);
      ck("zero", 0, ZERO_FLAG);
   endtask
   task results;
      $display("checks %0d fails %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge CLK);
      #1 RESET = 0; t_or; t_ret; t_ctl; results;
   end
endmodule // tb_top
`default_nettype wire
